// ---- hdl/emi_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "emi_cfg.svh"
module emi_top #(
   parameter int DW = 32
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic [31:0]   reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   output logic [31:0]        reg_rdata,
   input  wire logic          mem_req,
   input  wire logic          mem_write,
   input  wire logic [31:0]   mem_addr,
   input  wire logic [DW-1:0] mem_wdata,
   output logic               mem_busy,
   output logic               mem_done,
   output logic [DW-1:0]      mem_rdata,
   input  wire logic          interface_clock,
   output logic               sdram_select_n,
   output logic               async_select_n,
   output logic               out_enable_n,
   output logic               write_enable_n,
   output logic [1:0]         bank_select_outputs,
   output logic [12:0]        address_outputs,
   input  wire logic [DW-1:0] data_in,
   output logic [DW-1:0]      data_out,
   output logic               data_oe,
   input  wire logic          memory_wait_input,
   output logic               wait_irq
);
   // ****************************************************************
   // Register file, system clock domain.
   // ****************************************************************
   logic [31:0] async_wait_cycle_config, sdram_config, sdram_refresh_control, async_space_one_config, sdram_timing, sdram_self_refresh_exit_timing, nand_control;
   logic        raw_wait;
   logic        mask_wait;
   logic        irq_event;
   logic        done_event;
   logic [3:0]  burst_beats;
   emi_ecc_if   ecc_bus ();

   function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
      return a == r;
   endfunction : hit

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         async_wait_cycle_config <= `EMI_ASYNC_WAIT_CYCLE_CONFIG_RESET;
         sdram_config <= `EMI_SDRAM_CONFIG_RESET;
         sdram_refresh_control <= 32'h00000000;
         async_space_one_config <= `EMI_ASYNC_SPACE_ONE_CONFIG_RESET;
         sdram_timing <= 32'h00000000;
         sdram_self_refresh_exit_timing <= 32'h00000000;
         nand_control <= 32'h00000000;
      end else if (reg_write) begin
         if (hit(reg_addr, `EMI_ASYNC_WAIT_CYCLE_CONFIG_ADDR)) begin
            async_wait_cycle_config <= reg_wdata;
         end else if (hit(reg_addr, `EMI_SDRAM_CONFIG_ADDR)) begin
            // An x8 width would break the fixed burst, so such a write is dropped.
            if (reg_wdata[`EMI_SDWIDTH_LSB +: 2] != emi_pkg::EMI_W8 &&
                reg_wdata[`EMI_SDWIDTH_LSB +: 2] != 2'h3) begin
               sdram_config <= reg_wdata;
            end
         end else if (hit(reg_addr, `EMI_SDRAM_REFRESH_CONTROL_ADDR)) begin
            sdram_refresh_control <= reg_wdata;
         end else if (hit(reg_addr, `EMI_ASYNC_SPACE_ONE_CONFIG_ADDR)) begin
            if (reg_wdata[`EMI_AWIDTH_LSB +: 2] != 2'h3) begin
               async_space_one_config <= reg_wdata;
            end
         end else if (hit(reg_addr, `EMI_SDRAM_TIMING_ADDR)) begin
            sdram_timing <= reg_wdata;
         end else if (hit(reg_addr, `EMI_SDRAM_SELF_REFRESH_EXIT_TIMING_ADDR)) begin
            sdram_self_refresh_exit_timing <= reg_wdata;
         end else if (hit(reg_addr, `EMI_NAND_CONTROL_ADDR)) begin
            nand_control <= reg_wdata & ~(32'h1 << `EMI_ECC_START_BIT);
         end
      end
   end

   // A new wait edge in the same cycle as a clear keeps the flag set.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         raw_wait <= 1'b0;
      end else if (irq_event) begin
         raw_wait <= 1'b1;
      end else if (reg_write && (hit(reg_addr, `EMI_INTERRUPT_RAW_STATUS_ADDR) ||
                                 hit(reg_addr, `EMI_INTERRUPT_MASKED_STATUS_ADDR)) &&
                   reg_wdata[`EMI_WAIT_IRQ_BIT]) begin
         raw_wait <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask_wait <= 1'b0;
      end else if (reg_write && hit(reg_addr, `EMI_INTERRUPT_MASK_SET_ADDR) &&
                   reg_wdata[`EMI_WAIT_IRQ_BIT]) begin
         mask_wait <= 1'b1;
      end else if (reg_write && hit(reg_addr, `EMI_INTERRUPT_MASK_CLEAR_ADDR) &&
                   reg_wdata[`EMI_WAIT_IRQ_BIT]) begin
         mask_wait <= 1'b0;
      end
   end

   assign wait_irq = raw_wait & mask_wait;
   // Sixteen bytes per burst: eight beats at x16, four at x32.
   assign burst_beats = (sdram_config[`EMI_SDWIDTH_LSB +: 2] == emi_pkg::EMI_W16) ?
                        4'(`EMI_BURST_BYTES / 2) : 4'(`EMI_BURST_BYTES / 4);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (!reg_read) begin
         reg_rdata <= 32'h00000000;
      end else if (hit(reg_addr, `EMI_ASYNC_WAIT_CYCLE_CONFIG_ADDR)) begin
         reg_rdata <= async_wait_cycle_config;
      end else if (hit(reg_addr, `EMI_SDRAM_CONFIG_ADDR)) begin
         reg_rdata <= {burst_beats, sdram_config[27:0]};
      end else if (hit(reg_addr, `EMI_SDRAM_REFRESH_CONTROL_ADDR)) begin
         reg_rdata <= sdram_refresh_control;
      end else if (hit(reg_addr, `EMI_ASYNC_SPACE_ONE_CONFIG_ADDR)) begin
         reg_rdata <= async_space_one_config;
      end else if (hit(reg_addr, `EMI_SDRAM_TIMING_ADDR)) begin
         reg_rdata <= sdram_timing;
      end else if (hit(reg_addr, `EMI_SDRAM_SELF_REFRESH_EXIT_TIMING_ADDR)) begin
         reg_rdata <= sdram_self_refresh_exit_timing;
      end else if (hit(reg_addr, `EMI_INTERRUPT_RAW_STATUS_ADDR)) begin
         reg_rdata <= 32'(raw_wait) << `EMI_WAIT_IRQ_BIT;
      end else if (hit(reg_addr, `EMI_INTERRUPT_MASKED_STATUS_ADDR)) begin
         reg_rdata <= 32'(wait_irq) << `EMI_WAIT_IRQ_BIT;
      end else if (hit(reg_addr, `EMI_INTERRUPT_MASK_SET_ADDR) || hit(reg_addr, `EMI_INTERRUPT_MASK_CLEAR_ADDR)) begin
         reg_rdata <= 32'(mask_wait) << `EMI_WAIT_IRQ_BIT;
      end else if (hit(reg_addr, `EMI_NAND_CONTROL_ADDR)) begin
         reg_rdata <= nand_control;
      end else if (hit(reg_addr, `EMI_NAND_STATUS_ADDR)) begin
         reg_rdata <= (32'(ecc_bus.count) << `EMI_ECC_COUNT_LSB) | 32'(raw_wait);
      end else if (hit(reg_addr, `EMI_NANDECC_ADDR)) begin
         reg_rdata <= {8'h00, ecc_bus.code};
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ****************************************************************
   // Request side and crossings into the system clock domain.
   // ****************************************************************
   logic [31:0]   snap_addr;
   logic [DW-1:0] snap_wdata;
   logic          snap_write;
   logic [31:0]   snap_cfg;
   logic          snap_pol;
   logic          req_tgl;
   logic          done_tgl, done_s1, done_s2, done_s3;
   logic          irq_tgl, irq_s1, irq_s2, irq_s3;
   logic [DW-1:0] lnk_rdata;

   // Snapshot words stay still from the toggle until done, so the link may read them.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         snap_addr <= 32'h00000000;
         snap_wdata <= '0;
         snap_write <= 1'b0;
         snap_cfg <= `EMI_ASYNC_SPACE_ONE_CONFIG_RESET;
         snap_pol <= 1'b1;
         req_tgl <= 1'b0;
         mem_busy <= 1'b0;
      end else if (mem_req && !mem_busy) begin
         snap_addr <= mem_addr;
         snap_wdata <= mem_wdata;
         snap_write <= mem_write;
         snap_cfg <= async_space_one_config;
         snap_pol <= async_wait_cycle_config[`EMI_WAIT_POL_BIT];
         req_tgl <= ~req_tgl;
         mem_busy <= 1'b1;
      end else if (done_event) begin
         mem_busy <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {done_s1, done_s2, done_s3} <= 3'h0;
         {irq_s1, irq_s2, irq_s3} <= 3'h0;
      end else begin
         {done_s1, done_s2, done_s3} <= {done_tgl, done_s1, done_s2};
         {irq_s1, irq_s2, irq_s3} <= {irq_tgl, irq_s1, irq_s2};
      end
   end
   assign done_event = done_s2 ^ done_s3;
   assign irq_event = irq_s2 ^ irq_s3;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mem_done <= 1'b0;
         mem_rdata <= '0;
      end else begin
         mem_done <= done_event;
         if (done_event && !snap_write) begin
            mem_rdata <= lnk_rdata;
         end
      end
   end

   assign ecc_bus.clear = reg_write && hit(reg_addr, `EMI_NAND_CONTROL_ADDR) &&
                          reg_wdata[`EMI_ECC_START_BIT];
   assign ecc_bus.valid = done_event && nand_control[`EMI_NAND_MODE_BIT];
   assign ecc_bus.wide = snap_cfg[`EMI_AWIDTH_LSB +: 2] == emi_pkg::EMI_W16;
   assign ecc_bus.data = snap_write ? snap_wdata[15:0] : lnk_rdata[15:0];

   emi_ecc u_ecc (
      .clk   (clk),
      .reset (reset),
      .ecc   (ecc_bus)
   );

   // ****************************************************************
   // Asynchronous access engine, interface clock domain.
   // ****************************************************************
   emi_pkg::emi_state_t state;
   logic          req_s1, req_s2, req_s3;
   logic          wait_s1, wait_s2, wait_s3;
   logic [DW-1:0] data_s1, data_s2;
   logic [5:0]    cnt;
   logic          wait_act;
   logic [DW-1:0] width_mask;

   always_ff @(posedge interface_clock or posedge reset) begin
      if (reset) begin
         {req_s1, req_s2, req_s3} <= 3'h0;
         {wait_s1, wait_s2, wait_s3} <= 3'h0;
         data_s1 <= '0;
         data_s2 <= '0;
      end else begin
         {req_s1, req_s2, req_s3} <= {req_tgl, req_s1, req_s2};
         {wait_s1, wait_s2, wait_s3} <= {memory_wait_input, wait_s1, wait_s2};
         data_s1 <= data_in;
         data_s2 <= data_s1;
      end
   end

   // Polarity steers wait states only; the interrupt always uses the rising edge.
   assign wait_act = wait_s2 == snap_pol;
   assign width_mask = (snap_cfg[`EMI_AWIDTH_LSB +: 2] == emi_pkg::EMI_W8) ? DW'(8'hff) :
                       (snap_cfg[`EMI_AWIDTH_LSB +: 2] == emi_pkg::EMI_W16) ? DW'(16'hffff) :
                       '1;

   always_ff @(posedge interface_clock or posedge reset) begin
      if (reset) begin
         irq_tgl <= 1'b0;
      end else if (wait_s2 && !wait_s3) begin
         irq_tgl <= ~irq_tgl;
      end
   end

   always_ff @(posedge interface_clock or posedge reset) begin
      if (reset) begin
         state <= emi_pkg::EMI_IDLE;
         cnt <= 6'h00;
         async_select_n <= 1'b1;
         out_enable_n <= 1'b1;
         write_enable_n <= 1'b1;
         data_oe <= 1'b0;
         done_tgl <= 1'b0;
         lnk_rdata <= '0;
      end else begin
         case (state)
            emi_pkg::EMI_IDLE: begin
               if (req_s2 ^ req_s3) begin
                  state <= emi_pkg::EMI_SETUP;
                  cnt <= {2'h0, snap_cfg[`EMI_SETUP_LSB +: 4]};
                  async_select_n <= 1'b0;
                  data_oe <= snap_write;
               end
            end
            emi_pkg::EMI_SETUP: begin
               if (cnt == 6'h00) begin
                  state <= emi_pkg::EMI_STROBE;
                  cnt <= snap_cfg[`EMI_STROBE_LSB +: 6];
                  out_enable_n <= snap_write;
                  write_enable_n <= !snap_write;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
            emi_pkg::EMI_STROBE: begin
               // The wait pin is judged only at the strobe end, hence its lead time.
               if (cnt != 6'h00) begin
                  cnt <= cnt - 6'h01;
               end else if (!wait_act) begin
                  state <= emi_pkg::EMI_HOLD;
                  cnt <= {3'h0, snap_cfg[`EMI_HOLD_LSB +: 3]};
                  out_enable_n <= 1'b1;
                  write_enable_n <= 1'b1;
                  lnk_rdata <= data_s2 & width_mask;
               end
            end
            emi_pkg::EMI_HOLD: begin
               if (cnt == 6'h00) begin
                  state <= emi_pkg::EMI_IDLE;
                  async_select_n <= 1'b1;
                  data_oe <= 1'b0;
                  done_tgl <= ~done_tgl;
               end else begin
                  cnt <= cnt - 6'h01;
               end
            end
            default: begin
               state <= emi_pkg::EMI_IDLE;
            end
         endcase
      end
   end

   // Bank outputs take byte address bits 1:0, so x16 parts hang A0 on the upper one.
   assign bank_select_outputs = snap_addr[1:0];
   assign address_outputs = snap_addr[14:2];
   assign data_out = snap_wdata;
   // SDRAM sequencing is outside this engine; its select stays idle.
   assign sdram_select_n = 1'b1;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   sequence seq_strobe_end;
      state == emi_pkg::EMI_STROBE && cnt == 6'h00;
   endsequence
   sequence seq_wait_clear;
      seq_strobe_end ##0 !wait_act;
   endsequence

   AST_HOLD_AFTER_WAIT: assert property (@(posedge interface_clock) disable iff (reset)
      seq_wait_clear |=> state == emi_pkg::EMI_HOLD && out_enable_n && write_enable_n)
      else $error("Hold phase did not follow wait release.");
   AST_WAIT_STRETCH: assert property (@(posedge interface_clock) disable iff (reset)
      (seq_strobe_end ##0 wait_act) |=> state == emi_pkg::EMI_STROBE &&
      $stable(address_outputs) && $stable(async_select_n) &&
      $stable(out_enable_n) && $stable(write_enable_n))
      else $error("Strobe moved while wait was active.");
   AST_WAIT_POLARITY: assert property (@(posedge interface_clock) disable iff (reset)
      (seq_strobe_end ##0 (wait_s2 != snap_pol)) |=> state == emi_pkg::EMI_HOLD)
      else $error("Wait polarity not honoured.");
   AST_BANK_LOW: assert property (@(posedge interface_clock) disable iff (reset)
      !async_select_n |-> bank_select_outputs == snap_addr[1:0])
      else $error("Bank outputs do not carry low address bits.");
   AST_WORD_ADDR: assert property (@(posedge interface_clock) disable iff (reset)
      !async_select_n |-> address_outputs == snap_addr[14:2])
      else $error("Address outputs do not carry the word address.");
   AST_IRQ_EDGE: assert property (@(posedge clk) disable iff (reset)
      irq_event |=> raw_wait)
      else $error("Wait edge did not set raw status.");
   AST_MASK_SET: assert property (@(posedge clk) disable iff (reset)
      (reg_write && reg_addr == `EMI_INTERRUPT_MASK_SET_ADDR && reg_wdata[`EMI_WAIT_IRQ_BIT])
      |=> mask_wait ##0 (wait_irq == raw_wait))
      else $error("Mask set did not enable the interrupt.");
   AST_SDRAM_WIDTH: assert property (@(posedge clk) disable iff (reset)
      sdram_config[`EMI_SDWIDTH_LSB +: 2] != emi_pkg::EMI_W8)
      else $error("SDRAM width became x8.");
   AST_BURST_BYTES: assert property (@(posedge clk) disable iff (reset)
      (sdram_config[`EMI_SDWIDTH_LSB +: 2] == emi_pkg::EMI_W16 ? 32'(burst_beats) * 2 :
       32'(burst_beats) * 4) == `EMI_BURST_BYTES)
      else $error("SDRAM burst is not sixteen bytes.");
   AST_DONE_RELEASE: assert property (@(posedge clk) disable iff (reset)
      done_event |=> !mem_busy && mem_done)
      else $error("Completion did not release the request port.");
endmodule : emi_top
`default_nettype wire

// ---- hdl/emi_cfg.svh ----
`ifndef EMI_CFG_SVH
`define EMI_CFG_SVH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define EMI_ASYNC_WAIT_CYCLE_CONFIG_ADDR   32'hf0000004
`define EMI_SDRAM_CONFIG_ADDR    32'hf0000008
`define EMI_SDRAM_REFRESH_CONTROL_ADDR   32'hf000000c
`define EMI_ASYNC_SPACE_ONE_CONFIG_ADDR    32'hf0000010
`define EMI_SDRAM_TIMING_ADDR  32'hf0000020
`define EMI_SDRAM_SELF_REFRESH_EXIT_TIMING_ADDR 32'hf000003c
`define EMI_INTERRUPT_RAW_STATUS_ADDR    32'hf0000040
`define EMI_INTERRUPT_MASKED_STATUS_ADDR    32'hf0000044
`define EMI_INTERRUPT_MASK_SET_ADDR   32'hf0000048
`define EMI_INTERRUPT_MASK_CLEAR_ADDR   32'hf000004c
`define EMI_NAND_CONTROL_ADDR 32'hf0000060
`define EMI_NAND_STATUS_ADDR 32'hf0000064
`define EMI_NANDECC_ADDR 32'hf0000070

// ****************************************************************
// Field positions.
// ****************************************************************
`define EMI_WAIT_POL_BIT   0
`define EMI_SETUP_LSB      0
`define EMI_STROBE_LSB     4
`define EMI_HOLD_LSB       10
`define EMI_AWIDTH_LSB     13
`define EMI_SDWIDTH_LSB    14
`define EMI_BEATS_LSB      28
`define EMI_WAIT_IRQ_BIT   2
`define EMI_NAND_MODE_BIT  0
`define EMI_ECC_START_BIT  8
`define EMI_ECC_COUNT_LSB  16

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define EMI_ASYNC_SPACE_ONE_CONFIG_RESET     32'h00003fff
`define EMI_SDRAM_CONFIG_RESET     32'h00008000
`define EMI_ASYNC_WAIT_CYCLE_CONFIG_RESET    32'h00000001
`define EMI_BURST_BYTES    16
`define EMI_ECC_BLOCK      512
`define EMI_HOLD_LATENCY   4

`endif

// ---- hdl/emi_pkg.sv ----
`default_nettype none
package emi_pkg;
   typedef enum logic [1:0] {
      EMI_IDLE   = 2'b00,
      EMI_SETUP  = 2'b01,
      EMI_STROBE = 2'b10,
      EMI_HOLD   = 2'b11
   } emi_state_t;
   typedef enum logic [1:0] {
      EMI_W8  = 2'b00,
      EMI_W16 = 2'b01,
      EMI_W32 = 2'b10
   } emi_width_t;
endpackage : emi_pkg
`default_nettype wire

// ---- hdl/emi_ecc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface emi_ecc_if;
   logic        clear;
   logic        valid;
   logic        wide;
   logic [15:0] data;
   logic [23:0] code;
   logic [9:0]  count;
   modport src (output clear, output valid, output wide, output data,
                input code, input count);
   modport acc (input clear, input valid, input wide, input data,
                output code, output count);
endinterface : emi_ecc_if
`default_nettype wire

// ---- hdl/emi_ecc.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "emi_cfg.svh"
module emi_ecc (
   input  wire logic clk,
   input  wire logic reset,
   emi_ecc_if.acc    ecc
);
   // ****************************************************************
   // Column and line parities, a Hamming layout over the block.
   // ****************************************************************
   function automatic logic [23:0] emi_ecc_step(input logic [23:0] code,
                                                input logic [9:0] idx,
                                                input logic [7:0] b);
      logic [23:0] n;
      logic        bp;
      n = code;
      bp = ^b;
      n[0] = n[0] ^ (b[7] ^ b[5] ^ b[3] ^ b[1]);
      n[1] = n[1] ^ (b[6] ^ b[4] ^ b[2] ^ b[0]);
      n[2] = n[2] ^ (b[7] ^ b[6] ^ b[3] ^ b[2]);
      n[3] = n[3] ^ (b[5] ^ b[4] ^ b[1] ^ b[0]);
      n[4] = n[4] ^ (^b[7:4]);
      n[5] = n[5] ^ (^b[3:0]);
      for (int i = 0; i < 9; i++) begin
         if (idx[i]) begin
            n[6 + 2 * i] = n[6 + 2 * i] ^ bp;
         end else begin
            n[7 + 2 * i] = n[7 + 2 * i] ^ bp;
         end
      end
      return n;
   endfunction : emi_ecc_step

   logic [9:0] step;
   logic       room;
   assign step = ecc.wide ? 10'h002 : 10'h001;
   assign room = (ecc.count + step) <= 10'(`EMI_ECC_BLOCK);

   // Bytes past the block end are ignored so a long page cannot corrupt the code.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ecc.code <= 24'h000000;
         ecc.count <= 10'h000;
      end else if (ecc.clear) begin
         ecc.code <= 24'h000000;
         ecc.count <= 10'h000;
      end else if (ecc.valid && room) begin
         ecc.count <= ecc.count + step;
         if (ecc.wide) begin
            ecc.code <= emi_ecc_step(emi_ecc_step(ecc.code, ecc.count, ecc.data[7:0]),
                                     ecc.count + 10'h001, ecc.data[15:8]);
         end else begin
            ecc.code <= emi_ecc_step(ecc.code, ecc.count, ecc.data[7:0]);
         end
      end
   end

   AST_ECC_LIMIT: assert property (@(posedge clk) disable iff (reset)
      ecc.count <= 10'(`EMI_ECC_BLOCK)) else $error("ECC byte count passed block size.");
   AST_ECC_FREEZE: assert property (@(posedge clk) disable iff (reset)
      (ecc.count == 10'(`EMI_ECC_BLOCK) && !ecc.clear) |=> $stable(ecc.code))
      else $error("ECC changed after a full block.");
endmodule : emi_ecc
`default_nettype wire

// ---- bench/emi_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module emi_mem_model (
   input  wire logic        interface_clock,
   input  wire logic        wait_pol,
   input  wire logic [3:0]  stall,
   input  wire logic        async_select_n,
   input  wire logic        out_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic [1:0]  bank_select_outputs,
   input  wire logic [12:0] address_outputs,
   input  wire logic [31:0] data_out,
   input  wire logic        data_oe,
   output logic [31:0]      data_in,
   output logic             memory_wait_input,
   output logic [31:0]      wdata_seen,
   output logic [7:0]       strobe_len
);
   logic [3:0]  left = 4'h0;
   logic        sel_q = 1'b1;
   logic [31:0] bus_q = 32'h0;
   assign data_in = bus_q;
   // Wait asserts at wait_pol as the select falls, far ahead of strobe end, and stays two clocks or more.
   assign memory_wait_input = wait_pol ~^ (left != 4'h0);
   always @(posedge interface_clock) begin
      sel_q <= async_select_n;
      // A deselected bus shows no stale value, so it toggles.
      bus_q <= async_select_n ? ~bus_q
               : {16'hc3a5, 1'b0, address_outputs, bank_select_outputs};
      if (async_select_n) left <= 4'h0;
      else if (sel_q) left <= stall;
      else if ((!out_enable_n || !write_enable_n) && left != 4'h0) left <= left - 4'h1;
      if (sel_q && !async_select_n) strobe_len <= 8'h0;
      else if (!out_enable_n || !write_enable_n) strobe_len <= strobe_len + 8'h1;
      if (!write_enable_n && data_oe) wdata_seen <= data_out;
   end
endmodule : emi_mem_model
`default_nettype wire

// ---- bench/emi_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "emi_cfg.svh"
module emi_top_test;
   logic clk = 0, lclk = 0, reset = 1, reg_write = 0, reg_read = 0, mem_req = 0, mem_write = 0;
   logic wait_pol = 1, sdram_select_n, async_select_n, out_enable_n, write_enable_n, data_oe;
   logic memory_wait_input, wait_irq, mem_busy, mem_done;
   logic [31:0] reg_addr = 0, reg_wdata = 0, mem_addr = 0, mem_wdata = 0, reg_rdata, mem_rdata;
   logic [31:0] data_in, data_out, wdata_seen, v, a, d;
   logic [12:0] address_outputs;
   logic [1:0]  bank_select_outputs;
   logic [3:0]  stall = 0;
   logic [7:0]  strobe_len;
   int          num_errors = 0, checks_done = 0;
   emi_top u_emi_top (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_req(mem_req),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_busy(mem_busy),
      .mem_done(mem_done), .mem_rdata(mem_rdata), .interface_clock(lclk),
      .sdram_select_n(sdram_select_n), .async_select_n(async_select_n),
      .out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
      .bank_select_outputs(bank_select_outputs), .address_outputs(address_outputs),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .memory_wait_input(memory_wait_input), .wait_irq(wait_irq));
   emi_mem_model u_emi_mem_model (.interface_clock(lclk), .wait_pol(wait_pol), .stall(stall),
      .async_select_n(async_select_n), .out_enable_n(out_enable_n),
      .write_enable_n(write_enable_n), .bank_select_outputs(bank_select_outputs),
      .address_outputs(address_outputs), .data_out(data_out), .data_in(data_in),
      .data_oe(data_oe),
      .memory_wait_input(memory_wait_input), .wdata_seen(wdata_seen), .strobe_len(strobe_len));
   initial forever #5 clk = ~clk;
   initial begin
      #17;
      forever #62.5 lclk = ~lclk;
   end
   task automatic stop_test;
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] ad, output logic [31:0] dt);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      dt = reg_rdata;
   endtask : rd
   task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] dt);
      int n;
      mem_req <= 1'b1;
      mem_write <= w;
      mem_addr <= ad;
      mem_wdata <= dt;
      @(posedge clk);
      mem_req <= 1'b0;
      @(posedge clk);
      chk("busy", 1, mem_busy);
      for (n = 0; n < 3000 && mem_done !== 1'b1; n++) @(posedge clk);
      if (n == 3000) begin
         chk("done timeout", 1, 0);
         stop_test();
      end
      v = mem_rdata;
      chk("busy end", 0, mem_busy);
      repeat (2) @(posedge clk);
   endtask : acc
   initial begin
      v = $urandom(32'h3dc8);
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(`EMI_ASYNC_SPACE_ONE_CONFIG_ADDR, v); chk("async_space_one_config", 32'h3fff, v);
      rd(`EMI_ASYNC_WAIT_CYCLE_CONFIG_ADDR, v); chk("async_wait_cycle_config", 32'h1, v);
      rd(32'hf0000080, v); chk("unmapped", 32'h0, v);
      rd(`EMI_SDRAM_CONFIG_ADDR, v); chk("beats x32", 4, v[31:28]);
      wr(`EMI_SDRAM_CONFIG_ADDR, 32'h4000); rd(`EMI_SDRAM_CONFIG_ADDR, v); chk("beats x16", 8, v[31:28]);
      wr(`EMI_SDRAM_CONFIG_ADDR, 32'h0); rd(`EMI_SDRAM_CONFIG_ADDR, v); chk("x8 sdram", 8, v[31:28]);
      chk("sdram idle", 1, sdram_select_n);
      wr(`EMI_ASYNC_SPACE_ONE_CONFIG_ADDR, 32'h4421);
      repeat (6) begin
         a = $urandom & 32'h7fff;
         d = $urandom;
         acc(0, a, 0); chk("rdata", {16'hc3a5, 1'b0, a[14:0]}, v);
         chk("strobe", 3, strobe_len);
         acc(1, a, d); chk("wdata", d, wdata_seen);
         chk("oe idle", 0, data_oe);
      end
      wr(`EMI_ASYNC_SPACE_ONE_CONFIG_ADDR, 32'h2421);
      acc(0, 32'h2, 0); chk("rdata x16", {17'h0, 15'h2}, v);
      wr(`EMI_NAND_CONTROL_ADDR, 32'h101); rd(`EMI_NAND_STATUS_ADDR, v);
      chk("ecc count clr", 0, v[25:16]);
      // Setup of three gives the wait pin its lead of four link clocks.
      wr(`EMI_ASYNC_SPACE_ONE_CONFIG_ADDR, 32'h0423); acc(0, 32'h1, 0); chk("rdata x8", 1, v);
      // A lone set bit in byte zero sets its column bits and every odd line bit.
      rd(`EMI_NANDECC_ADDR, v); chk("ecc", 32'h00aaaaaa, v);
      rd(`EMI_NAND_STATUS_ADDR, v); chk("ecc count", 1, v[25:16]);
      stall <= 4'h4;
      acc(0, 32'h4, 0); chk("stretch", 1, strobe_len > 3);
      chk("irq masked", 0, wait_irq);
      rd(`EMI_INTERRUPT_RAW_STATUS_ADDR, v); chk("raw", 4, v & 32'h4);
      wr(`EMI_INTERRUPT_MASK_SET_ADDR, 32'h4); @(posedge clk); chk("irq on", 1, wait_irq);
      wr(`EMI_INTERRUPT_MASK_CLEAR_ADDR, 32'h4); @(posedge clk); chk("irq off", 0, wait_irq);
      wr(`EMI_ASYNC_WAIT_CYCLE_CONFIG_ADDR, 32'h0);
      wait_pol <= 1'b0;
      repeat (100) @(posedge clk);
      wr(`EMI_INTERRUPT_RAW_STATUS_ADDR, 32'h4); rd(`EMI_INTERRUPT_RAW_STATUS_ADDR, v); chk("raw clear", 0, v & 32'h4);
      acc(0, 32'h8, 0); chk("stretch low", 1, strobe_len > 3);
      repeat (100) @(posedge clk);
      rd(`EMI_INTERRUPT_RAW_STATUS_ADDR, v); chk("raw low pol", 4, v & 32'h4);
      stop_test();
   end
endmodule : emi_top_test
`default_nettype wire
